// ---- hdl/uart_fifo_control_dma_ready.sv ----
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module uart_fifo_control_dma_ready (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uart_fifo_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uart_fifo_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tsr_empty,
  input wire uart_fifo_pkg::rx_char_t rx_char,
  input wire logic rx_valid,
  input wire logic rx_timeout,
  output logic transmit_request_n,
  output logic receive_request_n,
  output logic uart_int,
  output logic irq
);
  import uart_fifo_pkg::*;

  fifo_control_t fcr_reg;
  logic [7:0] ier_reg;
  logic [4:0] evt_reg, mask_reg, evt_set;
  logic [CNT_W-1:0] rx_count_reg, tx_count_reg, rx_err_cnt_reg;
  logic [PTR_W-1:0] rx_rd_reg, rx_wr_reg, tx_rd_reg, tx_wr_reg;
  rx_char_t rx_mem [FIFO_DEPTH];
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic overrun_reg, timeout_reg, rx_hit_q_reg, tx_low_q_reg;
  logic txreq_n_reg, rxreq_n_reg;
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;

  logic wr_fire, rd_fire, fcr_wr, rx_push, rx_pop, tx_push, tx_pop, dma1;
  logic rx_hit, tx_low, head_err, rx_int, tmo_int, line_int, thr_int;
  logic [CNT_W-1:0] cap, rx_lvl, tx_lvl;
  logic [3:0] isr_code;
  logic [7:0] line_status_register, interrupt_status_register;
  rx_char_t head;
  fifo_control_t fcr_next;

  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] sel, input logic is_tx);
    logic [CNT_W-1:0] lvl;
    lvl = RX_LVL_0;
    case (sel)
      2'b00: lvl = is_tx ? TX_LVL_0 : RX_LVL_0;
      2'b01: lvl = is_tx ? TX_LVL_1 : RX_LVL_1;
      2'b10: lvl = is_tx ? TX_LVL_2 : RX_LVL_2;
      default: lvl = is_tx ? TX_LVL_3 : RX_LVL_3;
    endcase
    return lvl;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_DATA || a == OFS_IER || a == OFS_FCR || a == OFS_ISR ||
           a == OFS_LSR || a == OFS_EVT || a == OFS_MASK || a == OFS_LEVEL;
  endfunction

  // axi4-lite handshakes; one write and one read in flight
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign fcr_wr = wr_fire && awaddr_reg == OFS_FCR && wstrb_reg[0];

  // fifo depth collapses to one holding register while fifos are off
  assign cap = fcr_reg.fifo_en ? FIFO_FULL : HOLD_CAP; // see RQ14 RQ17
  assign rx_lvl = trig_level(fcr_reg.rx_trig, 1'b0); // see RQ11
  assign tx_lvl = trig_level(fcr_reg.tx_trig, 1'b1); // see RQ10
  assign dma1 = fcr_reg.fifo_en && fcr_reg.dma_mode; // see RQ16
  assign rx_hit = fcr_reg.fifo_en ? rx_count_reg >= rx_lvl : rx_count_reg != 6'h00; // see RQ11
  assign tx_low = fcr_reg.fifo_en ? tx_count_reg < tx_lvl : tx_count_reg == 6'h00; // see RQ10

  // a clear cycle blocks pushes so the fifo really ends empty
  assign rx_push = rx_valid && rx_count_reg < cap && !fcr_reg.rx_clear; // see RQ13
  assign rx_pop = rd_fire && s_axi_araddr == OFS_DATA && rx_count_reg != 6'h00;
  assign tx_push = wr_fire && awaddr_reg == OFS_DATA && wstrb_reg[0] && tx_count_reg < cap && !fcr_reg.tx_clear;
  assign tx_pop = tx_valid && tx_ready;
  assign tx_valid = tx_count_reg != 6'h00 && !fcr_reg.tx_clear;
  assign tx_data = tx_mem[tx_rd_reg];
  assign head = rx_mem[rx_rd_reg];
  assign head_err = rx_count_reg != 6'h00 && (head.brk || head.framing || head.parity);

  // enable 0 only turns fifos off; the rest is kept
  always_comb begin
    fcr_next = fcr_reg;
    fcr_next.rx_clear = 1'b0;
    fcr_next.tx_clear = 1'b0;
    if (fcr_wr) begin
      if (wdata_reg[0]) begin
        fcr_next = fifo_control_t'(wdata_reg[7:0]); // see RQ15
      end else begin
        fcr_next.fifo_en = 1'b0;
      end
      // toggling the enable flushes both fifos, data would be misframed otherwise
      if (wdata_reg[0] != fcr_reg.fifo_en) begin
        fcr_next.rx_clear = 1'b1;
        fcr_next.tx_clear = 1'b1;
      end
    end
  end

  // clear bits live one cycle, then read back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcr_reg <= fifo_control_t'(FCR_RESET);
    end else begin
      fcr_reg <= fcr_next; // see RQ12 RQ13 RQ14 RQ16
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ier_reg <= IER_RESET;
      mask_reg <= EVT_RESET;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == OFS_IER) begin
        ier_reg <= wdata_reg[7:0];
      end
      if (awaddr_reg == OFS_MASK) begin
        mask_reg <= wdata_reg[4:0];
      end
    end
  end

  // receive fifo, shift register side untouched by the clear
  always_ff @(posedge aclk) begin
    if (rx_push) begin
      rx_mem[rx_wr_reg] <= rx_char;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || fcr_reg.rx_clear) begin
      rx_count_reg <= '0; // see RQ13
      rx_rd_reg <= '0;
      rx_wr_reg <= '0;
      rx_err_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_reg <= PTR_W'(rx_wr_reg + 5'h01);
      end
      if (rx_pop) begin
        rx_rd_reg <= PTR_W'(rx_rd_reg + 5'h01);
      end
      case ({rx_push, rx_pop})
        2'b10: rx_count_reg <= CNT_W'(rx_count_reg + 6'h01); // see RQ3
        2'b01: rx_count_reg <= CNT_W'(rx_count_reg - 6'h01);
        default: rx_count_reg <= rx_count_reg;
      endcase
      case ({rx_push && (rx_char.brk || rx_char.framing || rx_char.parity), rx_pop && head_err})
        2'b10: rx_err_cnt_reg <= CNT_W'(rx_err_cnt_reg + 6'h01);
        2'b01: rx_err_cnt_reg <= CNT_W'(rx_err_cnt_reg - 6'h01);
        default: rx_err_cnt_reg <= rx_err_cnt_reg;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (tx_push) begin
      tx_mem[tx_wr_reg] <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || fcr_reg.tx_clear) begin
      tx_count_reg <= '0; // see RQ12
      tx_rd_reg <= '0;
      tx_wr_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_wr_reg <= PTR_W'(tx_wr_reg + 5'h01);
      end
      if (tx_pop) begin
        tx_rd_reg <= PTR_W'(tx_rd_reg + 5'h01);
      end
      case ({tx_push, tx_pop})
        2'b10: tx_count_reg <= CNT_W'(tx_count_reg + 6'h01);
        2'b01: tx_count_reg <= CNT_W'(tx_count_reg - 6'h01);
        default: tx_count_reg <= tx_count_reg;
      endcase
    end
  end

  // overrun clears on a line status read, timeout on a data read; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      if (rx_valid && !rx_push) begin
        overrun_reg <= 1'b1;
      end else if (rd_fire && s_axi_araddr == OFS_LSR) begin
        overrun_reg <= 1'b0;
      end
      if (rx_timeout && rx_count_reg != 6'h00) begin
        timeout_reg <= 1'b1;
      end else if (rx_pop || fcr_reg.rx_clear) begin
        timeout_reg <= 1'b0;
      end
    end
  end

  assign line_status_register = {fcr_reg.fifo_en && rx_err_cnt_reg != 6'h00, // see RQ5
                tx_count_reg == 6'h00 && tsr_empty, tx_count_reg == 6'h00,
                head_err && head.brk, head_err && head.framing, head_err && head.parity,
                overrun_reg, rx_count_reg != 6'h00}; // see RQ3

  // all enables 3..0 low leaves only line status for polling
  assign rx_int = ier_reg[0] && rx_hit; // see RQ1 RQ4
  assign tmo_int = ier_reg[0] && timeout_reg;
  assign line_int = ier_reg[2] && (overrun_reg || head_err);
  assign thr_int = ier_reg[1] && tx_low; // see RQ10
  assign uart_int = rx_int || tmo_int || line_int || thr_int;

  always_comb begin
    if (line_int) begin
      isr_code = ISR_LINE;
    end else if (tmo_int) begin
      isr_code = ISR_RXTMO;
    end else if (rx_int) begin
      isr_code = ISR_RXDATA; // see RQ2
    end else if (thr_int) begin
      isr_code = ISR_TXEMPTY;
    end else begin
      isr_code = ISR_NONE;
    end
  end
  assign interrupt_status_register = {fcr_reg.fifo_en, fcr_reg.fifo_en, 2'b00, isr_code};

  // dma request pins; mode 1 holds its level between the two thresholds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txreq_n_reg <= TXREQ_N_RESET;
      rxreq_n_reg <= RXREQ_N_RESET;
    end else if (!dma1) begin
      txreq_n_reg <= tx_count_reg != 6'h00; // see RQ6
      rxreq_n_reg <= rx_count_reg == 6'h00; // see RQ7
    end else begin
      if (tx_count_reg == FIFO_FULL) begin
        txreq_n_reg <= 1'b1; // see RQ8
      end else if (tx_low) begin
        txreq_n_reg <= 1'b0;
      end
      if (rx_hit || timeout_reg) begin
        rxreq_n_reg <= 1'b0; // see RQ9
      end else if (rx_count_reg == 6'h00) begin
        rxreq_n_reg <= 1'b1;
      end
    end
  end
  assign transmit_request_n = txreq_n_reg;
  assign receive_request_n = rxreq_n_reg;

  // sticky event bits, write one to clear, a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hit_q_reg <= 1'b0;
      tx_low_q_reg <= 1'b0;
    end else begin
      rx_hit_q_reg <= rx_hit;
      tx_low_q_reg <= tx_low;
    end
  end

  always_comb begin
    evt_set = '0;
    evt_set[EVT_RX_TRIG] = rx_hit && !rx_hit_q_reg;
    evt_set[EVT_TX_LOW] = tx_low && !tx_low_q_reg;
    evt_set[EVT_RX_ERR] = rx_push && (rx_char.brk || rx_char.framing || rx_char.parity);
    evt_set[EVT_OVERRUN] = rx_valid && !rx_push;
    evt_set[EVT_TIMEOUT] = rx_timeout;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_reg <= EVT_RESET;
    end else if (wr_fire && wstrb_reg[0] && awaddr_reg == OFS_EVT) begin
      evt_reg <= (evt_reg & ~wdata_reg[4:0]) | evt_set;
    end else begin
      evt_reg <= evt_reg | evt_set;
    end
  end
  assign irq = |(evt_reg & mask_reg);

  // write channel: address and data land in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read data is captured with its side effects in the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_DATA: rdata_reg <= {24'h000000, rx_count_reg != 6'h00 ? head.data : 8'h00};
        OFS_IER: rdata_reg <= {24'h000000, ier_reg};
        OFS_FCR: rdata_reg <= {24'h000000, fcr_reg};
        OFS_ISR: rdata_reg <= {24'h000000, interrupt_status_register};
        OFS_LSR: rdata_reg <= {24'h000000, line_status_register};
        OFS_EVT: rdata_reg <= {27'h0000000, evt_reg};
        OFS_MASK: rdata_reg <= {27'h0000000, mask_reg};
        OFS_LEVEL: rdata_reg <= {18'h00000, tx_count_reg, 2'b00, rx_count_reg};
        default: rdata_reg <= '0;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence fcr_write_no_enable;
    fcr_wr && !wdata_reg[0];
  endsequence

  sequence tx_clear_pulse;
    fcr_reg.tx_clear ##1 1'b1;
  endsequence

  rx_int_level_a: assert property (fcr_reg.fifo_en && ier_reg[0] && rx_count_reg >= rx_lvl |-> uart_int) // see RQ1
    else $error("rx trigger reached without interrupt");
  isr_rx_code_a: assert property (ier_reg[3:0] == 4'h1 && fcr_reg.fifo_en && rx_hit && !timeout_reg
    |-> interrupt_status_register[3:0] == ISR_RXDATA) // see RQ2
    else $error("rx data source missing from status");
  isr_rx_drop_a: assert property (ier_reg[3:0] == 4'h1 && fcr_reg.fifo_en && rx_count_reg < rx_lvl && !timeout_reg
    |-> interrupt_status_register[3:0] == ISR_NONE && !uart_int) // see RQ2
    else $error("rx source shown below trigger");
  data_ready_a: assert property (rx_push |=> line_status_register[0] ##0 rx_count_reg != 6'h00) // see RQ3
    else $error("data ready not set after push");
  polled_quiet_a: assert property (ier_reg[3:0] == 4'h0 |-> !uart_int) // see RQ4
    else $error("interrupt raised in polled mode");
  lsr_tx_both_a: assert property (line_status_register[6] |-> line_status_register[5] && tsr_empty) // see RQ5
    else $error("tx all empty without fifo empty");
  txreq_mode0_a: assert property (!dma1 && tx_count_reg == 6'h00 |=> !transmit_request_n) // see RQ6
    else $error("tx request high with empty tx side");
  rxreq_mode0_a: assert property (!dma1 && rx_count_reg != 6'h00 |=> !receive_request_n) // see RQ7
    else $error("rx request high with data held");
  txreq_full_a: assert property (dma1 && tx_count_reg == FIFO_FULL |=> transmit_request_n) // see RQ8
    else $error("tx request low with full fifo");
  rxreq_block_a: assert property (dma1 && rx_count_reg >= rx_lvl |=> !receive_request_n) // see RQ9
    else $error("rx request not low at trigger");
  tx_clear_done_a: assert property (tx_clear_pulse |-> ##1 tx_count_reg == 6'h00 && !fcr_reg.tx_clear) // see RQ12
    else $error("tx clear did not empty and self clear");
  rx_clear_done_a: assert property (fcr_reg.rx_clear |=> rx_count_reg == 6'h00 && !fcr_reg.rx_clear) // see RQ13
    else $error("rx clear did not empty and self clear");
  fcr_gate_a: assert property (fcr_write_no_enable |=> !fcr_reg.fifo_en && $stable(fcr_reg.rx_trig)
    && $stable(fcr_reg.tx_trig) && $stable(fcr_reg.dma_mode)) // see RQ15
    else $error("control bits changed without enable");
  fill_bound_a: assert property ((fcr_reg.rx_clear || rx_count_reg <= cap) && tx_count_reg <= FIFO_FULL) // see RQ17
    else $error("fifo fill beyond capacity");
endmodule
`default_nettype wire

// ---- hdl/uart_fifo_pkg.sv ----
// Behaviour
// RQ1: fifos on and rx interrupt enabled: rx interrupt while fill at or above trigger.
// RQ2: interrupt status shows rx data available at trigger, clears below it.
// RQ3: data ready set when a character enters rx fifo, cleared when empty.
// RQ4: fifos on with interrupt enables 3..0 clear means polled mode via line status.
// RQ5: line status: errors in bits 4..1, tx empty 5, tx all empty 6, fifo error 7.
// RQ6: fifos off or dma mode 0: transmit request low while no tx character held.
// RQ7: fifos off or dma mode 0: receive request low while any rx character held.
// RQ8: dma mode 1: transmit request high when tx full, low at tx trigger.
// RQ9: dma mode 1: receive request low at trigger or timeout, high once empty.
// RQ10: tx trigger field 00/01/10/11 gives 16/8/24/30; empty interrupt below it.
// RQ11: rx trigger field 00/01/10/11 gives 8/16/24/28; fifo still fills to full.
// RQ12: tx clear bit empties tx fifo and counters, then reads back zero.
// RQ13: rx clear bit empties rx fifo and counters, then reads back zero.
// RQ14: fifo enable turns both fifos on; off means single holding register.
// RQ15: other fifo control bits are written only when the same write sets enable.
// RQ16: dma mode bit selects per-character mode 0 or trigger-based block mode 1.
// RQ17: each fifo holds 32 bytes; counters span empty through full.
package uart_fifo_pkg;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int PTR_W = 5;
  localparam int ADDR_W = 8;
  localparam logic [CNT_W-1:0] FIFO_FULL = 6'h20;
  localparam logic [CNT_W-1:0] HOLD_CAP = 6'h01;
  localparam logic [CNT_W-1:0] RX_LVL_0 = 6'h08;
  localparam logic [CNT_W-1:0] RX_LVL_1 = 6'h10;
  localparam logic [CNT_W-1:0] RX_LVL_2 = 6'h18;
  localparam logic [CNT_W-1:0] RX_LVL_3 = 6'h1c;
  localparam logic [CNT_W-1:0] TX_LVL_0 = 6'h10;
  localparam logic [CNT_W-1:0] TX_LVL_1 = 6'h08;
  localparam logic [CNT_W-1:0] TX_LVL_2 = 6'h18;
  localparam logic [CNT_W-1:0] TX_LVL_3 = 6'h1e;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FCR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ISR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LSR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h1c;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [4:0] EVT_RESET = 5'h00;
  localparam logic TXREQ_N_RESET = 1'b0;
  localparam logic RXREQ_N_RESET = 1'b1;
  localparam int EVT_RX_TRIG = 0;
  localparam int EVT_TX_LOW = 1;
  localparam int EVT_RX_ERR = 2;
  localparam int EVT_OVERRUN = 3;
  localparam int EVT_TIMEOUT = 4;
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_LINE = 4'h6;
  localparam logic [3:0] ISR_RXDATA = 4'h4;
  localparam logic [3:0] ISR_RXTMO = 4'hc;
  localparam logic [3:0] ISR_TXEMPTY = 4'h2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // field order matches the control byte, bit 7 first
  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic dma_mode;
    logic tx_clear;
    logic rx_clear;
    logic fifo_en;
  } fifo_control_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic [7:0] data;
  } rx_char_t;
endpackage

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import uart_fifo_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic stall = 1, rx_valid = 0, rx_timeout = 0;
  logic [7:0] awaddr = 0, araddr = 0, tx_data;
  logic [31:0] wdata = 0, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, tsr_empty, txn, rxn, uart_int, irq;
  rx_char_t rx_char = '0;
  int bad_count = 0, checks_done = 0, cyc = 0;
  int unsigned seed = 99888;
  int rxl[4] = '{8, 16, 24, 28};
  int txl[4] = '{16, 8, 24, 30};
  logic [7:0] rq[$];
  logic [7:0] tx_seen = 0;
  always @(posedge aclk) if (tx_valid && tx_ready) tx_seen <= tx_data;
  always #12.5 aclk = ~aclk;
  uart_fifo_control_dma_ready uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tsr_empty(tsr_empty), .rx_char(rx_char), .rx_valid(rx_valid),
    .rx_timeout(rx_timeout), .transmit_request_n(txn), .receive_request_n(rxn),
    .uart_int(uart_int), .irq(irq));
  uart_shifter_model shifter (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data),
    .tx_valid(tx_valid), .stall(stall), .tx_ready(tx_ready), .tsr_empty(tsr_empty));
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit dn;
    dn = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!dn) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        dn = 1;
        rsp = bresp;
      end
    end
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    bit dn;
    dn = 0;
    araddr <= a;
    arvalid <= 1;
    while (!dn) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        dn = 1;
        rd = rdata;
        rsp = rresp;
      end
    end
    @(posedge aclk);
  endtask
  task automatic push(input int n, input logic [2:0] f);
    logic [7:0] b;
    rx_valid <= 1;
    repeat (n) begin
      b = 8'(xs());
      rx_char <= rx_char_t'({f, b});
      rq.push_back(b);
      @(posedge aclk);
    end
    rx_valid <= 0;
    @(posedge aclk);
  endtask
  task automatic pop(input int n);
    repeat (n) begin
      rdr(OFS_DATA);
      chk("rx data", rd, {24'h0, rq.pop_front()});
    end
  endtask
  task automatic txw(input int n);
    repeat (n) wr(OFS_DATA, xs() & 32'hff);
  endtask
  task automatic st();
    repeat (3) @(posedge aclk);
  endtask
  // ceiling well above the thousand or so cycles the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("txn rst", txn, TXREQ_N_RESET);
    chk("rxn rst", rxn, RXREQ_N_RESET);
    rdr(OFS_FCR);
    chk("fcr rst", rd, 32'h0);
    wr(OFS_FCR, 32'hce);
    rdr(OFS_FCR);
    chk("fcr ignored", rd, 32'h0);
    rdr(8'h40);
    chk("unmapped", rsp, RESP_SLVERR);
    $display("test reset done");
    wr(OFS_DATA, 32'h5a);
    push(1, 3'h0);
    st();
    chk("txn loaded", txn, 1);
    chk("rxn held", rxn, 0);
    pop(1);
    stall <= 0;
    repeat (12) @(posedge aclk);
    chk("txn empty", txn, 0);
    chk("tx data", tx_seen, 32'h5a);
    chk("rxn empty", rxn, 1);
    rdr(OFS_LSR);
    chk("lsr idle", rd, 32'h60);
    stall <= 1;
    $display("test mode0 done");
    wr(OFS_IER, 1);
    wr(OFS_MASK, 0);
    for (int t = 0; t < 4; t++) begin
      wr(OFS_FCR, (t << 6) | 3);
      push(rxl[t] - 1, 3'h0);
      st();
      chk("int below", uart_int, 0);
      chk("rxn fifo", rxn, 0);
      push(1, 3'h0);
      st();
      chk("int at", uart_int, 1);
      rdr(OFS_ISR);
      chk("isr rx", rd, 32'hc4);
      pop(1);
      chk("int drop", uart_int, 0);
      rdr(OFS_ISR);
      chk("isr none", rd, 32'hc1);
      wr(OFS_FCR, (t << 6) | 3);
      rq.delete();
      rdr(OFS_FCR);
      chk("clr self", rd, (t << 6) | 1);
      rdr(OFS_LEVEL);
      chk("rx clr", rd[5:0], 0);
    end
    chk("irq masked", irq, 0);
    wr(OFS_MASK, 1);
    chk("irq on", irq, 1);
    wr(OFS_EVT, 32'h1f);
    chk("irq w1c", irq, 0);
    $display("test rx trigger done");
    wr(OFS_IER, 2);
    for (int t = 0; t < 4; t++) begin
      wr(OFS_FCR, (t << 4) | 32'h0d);
      txw(txl[t] - 1);
      st();
      chk("tx int", uart_int, 1);
      chk("txn low", txn, 0);
      txw(1);
      st();
      chk("tx int off", uart_int, 0);
      txw(32 - txl[t]);
      st();
      chk("txn full", txn, 1);
      rdr(OFS_LEVEL);
      chk("tx full", rd[13:8], 32);
      wr(OFS_FCR, (t << 4) | 32'h0d);
      st();
      rdr(OFS_LEVEL);
      chk("tx clr", rd[13:8], 0);
      chk("txn trig", txn, 0);
    end
    $display("test tx trigger done");
    wr(OFS_IER, 0);
    wr(OFS_FCR, 32'h0b);
    push(7, 3'h0);
    st();
    chk("rxn below", rxn, 1);
    push(1, 3'h0);
    st();
    chk("rxn trig", rxn, 0);
    chk("polled int", uart_int, 0);
    pop(1);
    st();
    chk("rxn hold", rxn, 0);
    pop(7);
    st();
    chk("rxn done", rxn, 1);
    push(1, 3'h4);
    rx_timeout <= 1;
    @(posedge aclk);
    rx_timeout <= 0;
    st();
    chk("rxn tmo", rxn, 0);
    rdr(OFS_LSR);
    chk("lsr err", rd, 32'hf1);
    pop(1);
    st();
    chk("rxn tmo end", rxn, 1);
    $display("test dma1 rx done");
    finish_test();
  end
endmodule
`default_nettype wire

// ---- tb/uart_shifter_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module uart_shifter_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic stall,
  output logic tx_ready,
  output logic tsr_empty
);
  // each byte keeps the shifter busy, so tsr empty lags the fifo empty bit
  int busy;
  assign tx_ready = !stall && busy == 0;
  assign tsr_empty = busy == 0;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      busy <= 0;
    else if (tx_valid && tx_ready)
      busy <= 4;
    else if (busy != 0)
      busy <= busy - 1;
  end
endmodule
`default_nettype wire
